// File: pkg/scer_pkg.sv
// Functional notes
// - Bad or out-of-range channel replies code 1
// - Too few parameters replies code 3
// - Channel unfit for task replies code 4
// - Parity or framing fault replies code 9
// - Text replies start with "Error, "
// - Unrecognized command echoes command, ends CR
// - Partly recognized command echoes command, ends CR
// - Unit select needs CR right after digits
// - Selected unit answers until another select
package scer_pkg;

   // ASCII characters used by the interpreter
   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] CH_BANG  = 8'h21;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_COLON = 8'h3A;

   // Numeric error codes
   localparam logic [3:0] CODE_CHAN   = 4'h1;
   localparam logic [3:0] CODE_SYNTAX = 4'h3;
   localparam logic [3:0] CODE_TASK   = 4'h4;
   localparam logic [3:0] CODE_PARITY = 4'h9;

   // Highest legal channel number
   localparam logic [7:0] CHAN_MAX = 8'h07;

   // Command buffer depth for echo
   localparam int CMD_DEPTH = 32;

   // Reset values
   localparam logic [7:0] ADDR_RST = 8'h00;

   // Verdict that the command parser hands in with each command
   typedef enum logic [2:0] {
      SCER_OK,
      SCER_UNKNOWN,
      SCER_PARTIAL,
      SCER_SYNTAX,
      SCER_TASK
   } scer_verdict_t;

   // Received character from the serial receiver
   typedef struct packed {
      logic [7:0] data;
      logic       parity_err;
      logic       frame_err;
   } scer_rx_t;

   // Check summary of a finished command
   typedef struct packed {
      scer_verdict_t verdict;
      logic          has_chan;
      logic [7:0]    chan;
   } scer_check_t;

endpackage

// File: hw/scer_hex_digit.sv
`timescale 1ns/1ps
// Converts one four-bit value to an ASCII hex digit
module scer_hex_digit (
   input  wire logic [3:0] i_val,
   output logic      [7:0] o_char
);
   // Digits 0-9 then A-F
   always_comb begin
      if (i_val < 4'hA) begin
         o_char = 8'h30 + {4'h0, i_val};
      end else begin
         o_char = 8'h37 + {4'h0, i_val};
      end
   end
endmodule // scer_hex_digit

// File: hw/scer_responder.sv
`timescale 1ns/1ps
// Error responder: collects command characters, judges the finished
// command, and streams the reply byte by byte to the transmitter.
module scer_responder (
   input  wire logic              i_core_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_rx_valid,   // One pulse per char
   input  wire scer_pkg::scer_rx_t i_rx,
   input  wire scer_pkg::scer_check_t i_check,  // Valid with the CR
   input  wire logic [7:0]        i_unit_addr,  // Own address, 00 = none
   input  wire logic              i_tx_ready,
   output logic                   o_tx_valid,
   output logic [7:0]             o_tx_data,
   output logic                   o_selected,
   output logic                   o_busy
);
   import scer_pkg::*;

   // Reply kinds
   typedef enum logic [1:0] {
      RK_CODE, RK_UNK, RK_PART, RK_TERM
   } scer_kind_t;

   // Reply sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_PREFIX, ST_TEXT, ST_ECHO, ST_CODE, ST_CR, ST_DONE
   } scer_state_t;

   localparam int TXT_LEN = 40;

   // Text bodies, stored right-aligned, padded with zero bytes
   localparam logic [8*TXT_LEN-1:0] TXT_UNK =
      {{18{8'h00}}, "Unrecognized Command: "};
   localparam logic [8*TXT_LEN-1:0] TXT_PART =
      {{10{8'h00}}, "Command not fully recognized: "};
   localparam logic [8*TXT_LEN-1:0] TXT_TERM =
      {{3{8'h00}}, "Address command must be CR terminated"};
   localparam logic [8*7-1:0] TXT_PREFIX = "Error, ";

   logic [7:0]        cmd_buf [CMD_DEPTH];  // Echo store
   logic [5:0]        cmd_len;              // Chars held
   logic              line_fault;           // Parity/framing seen
   logic              selected;             // Unit answers commands
   scer_state_t       state;
   scer_kind_t        kind;
   logic [3:0]        code;
   logic [5:0]        idx;                  // Position in text
   logic [7:0]        txt_char;
   logic [7:0]        code_char;
   logic              end_cmd;
   logic              sel_cmd;
   logic [7:0]        sel_addr;
   logic [7:0]        hi_char;
   logic [7:0]        lo_char;
   logic [3:0]        hi_nib;
   logic [3:0]        lo_nib;
   logic [8*TXT_LEN-1:0] txt_sel;
   logic [5:0]        echo_len;             // Chars to echo back
   logic              fault_now;            // Fault seen, this char too
   logic              live;                 // Unit may answer
   logic              load;                 // Output byte register free
   logic              reply_due;            // Finished command needs reply
   logic              start_reply;          // Reply starts this cycle
   scer_kind_t        next_kind;
   logic [3:0]        next_code;

   // End of command is a CR with no reply in progress
   assign end_cmd = i_rx_valid && (i_rx.data == CH_CR) &&
                    (state == ST_IDLE);
   assign sel_cmd = (cmd_len != 6'd0) && (cmd_buf[0] == CH_BANG);
   assign hi_char = cmd_buf[1];
   assign lo_char = cmd_buf[2];
   // A fault on the closing CR itself must count as well
   assign fault_now = line_fault ||
                      (i_rx_valid && (i_rx.parity_err || i_rx.frame_err));
   assign live = selected || (i_unit_addr == ADDR_RST);
   // Next byte may be loaded once the current one is taken
   assign load = !o_tx_valid || i_tx_ready;

   // ASCII hex digit to nibble; invalid yields 4'h0
   function automatic logic [3:0] nib(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) begin
         nib = c[3:0];
      end else if (c >= 8'h41 && c <= 8'h46) begin
         nib = c[3:0] + 4'h9;
      end else begin
         nib = 4'h0;
      end
   endfunction
   assign hi_nib   = nib(hi_char);
   assign lo_nib   = nib(lo_char);
   assign sel_addr = {hi_nib, lo_nib};

   // Collect command characters; extra chars past depth are dropped
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         cmd_len  <= 6'd0;
         echo_len <= 6'd0;
      end else if (end_cmd) begin
         // Buffer is kept for the echo; chars are dropped while busy
         cmd_len  <= 6'd0;
         echo_len <= cmd_len;
      end else if (i_rx_valid && state == ST_IDLE &&
                   cmd_len < 6'(CMD_DEPTH)) begin
         cmd_buf[cmd_len[4:0]] <= i_rx.data;
         cmd_len <= cmd_len + 6'd1;
      end
   end

   // Any faulty char taints the whole command
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || end_cmd) begin
         line_fault <= 1'b0;
      end else if (i_rx_valid && state == ST_IDLE &&
                   (i_rx.parity_err || i_rx.frame_err)) begin
         line_fault <= 1'b1;
      end
   end

   // Unit selection stays until another select names another unit
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         selected <= 1'b0;
      end else if (end_cmd && sel_cmd && !fault_now &&
                   cmd_len == 6'd3) begin
         selected <= (sel_addr == i_unit_addr);
      end
   end

   // Judge the finished command; a line fault outranks every verdict
   always_comb begin
      next_kind = RK_CODE;
      next_code = 4'h0;
      reply_due = 1'b0;
      if (live && fault_now) begin
         next_code = CODE_PARITY;
         reply_due = 1'b1;
      end else if (live && sel_cmd && cmd_len > 6'd3) begin
         // Only a listening unit complains, so drops do not collide
         next_kind = RK_TERM;
         reply_due = 1'b1;
      end else if (live && !sel_cmd) begin
         if (i_check.verdict == SCER_UNKNOWN) begin
            next_kind = RK_UNK;
            reply_due = 1'b1;
         end else if (i_check.verdict == SCER_PARTIAL) begin
            next_kind = RK_PART;
            reply_due = 1'b1;
         end else if (i_check.verdict == SCER_SYNTAX) begin
            next_code = CODE_SYNTAX;
            reply_due = 1'b1;
         end else if (i_check.has_chan &&
                      i_check.chan > CHAN_MAX) begin
            next_code = CODE_CHAN;
            reply_due = 1'b1;
         end else if (i_check.verdict == SCER_TASK) begin
            next_code = CODE_TASK;
            reply_due = 1'b1;
         end
      end
   end
   assign start_reply = end_cmd && reply_due;

   // Reply sequencer; steps whenever the output byte is free, so the
   // pointer always names the byte being loaded, never a stale one
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         state <= ST_IDLE;
         kind  <= RK_CODE;
         code  <= 4'h0;
         idx   <= 6'd0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               idx <= 6'd0;
               if (start_reply) begin
                  kind  <= next_kind;
                  code  <= next_code;
                  state <= (next_kind == RK_CODE) ? ST_CODE : ST_PREFIX;
               end
            end
            ST_PREFIX: if (load) begin
               if (idx == 6'd6) begin
                  idx   <= 6'd0;
                  state <= ST_TEXT;
               end else begin
                  idx <= idx + 6'd1;
               end
            end
            ST_TEXT: if (load) begin
               if (idx == 6'(TXT_LEN - 1)) begin
                  idx   <= 6'd0;
                  state <= (kind == RK_TERM) ? ST_CR : ST_ECHO;
               end else begin
                  idx <= idx + 6'd1;
               end
            end
            ST_ECHO: if (load) begin
               // Buffer holds the command without its CR
               if (idx + 6'd1 >= echo_len) begin
                  state <= ST_CR;
               end
               idx <= idx + 6'd1;
            end
            ST_CODE: if (load) begin
               state <= ST_CR;
            end
            ST_CR: if (load) begin
               state <= ST_DONE;
            end
            // Wait until the closing CR has been taken
            ST_DONE: if (load) begin
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Current text character, padding bytes skipped as zero
   always_comb begin
      unique case (kind)
         RK_UNK:  txt_sel = TXT_UNK;
         RK_PART: txt_sel = TXT_PART;
         default: txt_sel = TXT_TERM;
      endcase
      txt_char = txt_sel[8*(TXT_LEN-1-int'(idx)) +: 8];
   end

   scer_hex_digit u_code_digit (
      .i_val  (code),
      .o_char (code_char)
   );

   // Registered transmit byte; held untouched while the host stalls
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
      end else if (load) begin
         unique case (state)
            ST_PREFIX: begin
               o_tx_valid <= 1'b1;
               o_tx_data  <= TXT_PREFIX[8*(6-int'(idx)) +: 8];
            end
            ST_TEXT: begin
               // Pad bytes cost a cycle but are never offered
               o_tx_valid <= (txt_char != 8'h00);
               o_tx_data  <= txt_char;
            end
            ST_ECHO: begin
               o_tx_valid <= (idx < echo_len);
               o_tx_data  <= cmd_buf[idx[4:0]];
            end
            ST_CODE: begin
               o_tx_valid <= 1'b1;
               o_tx_data  <= code_char;
            end
            ST_CR: begin
               o_tx_valid <= 1'b1;
               o_tx_data  <= CH_CR;
            end
            default: o_tx_valid <= 1'b0;
         endcase
      end
   end

   // Status outputs; busy runs from the closing CR of the command to
   // acceptance of the reply's last byte, exactly while not idle
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_selected <= 1'b0;
         o_busy     <= 1'b0;
      end else begin
         o_selected <= selected;
         if (!o_busy) begin
            o_busy <= start_reply;
         end else begin
            o_busy <= !(state == ST_DONE && load);
         end
      end
   end
endmodule // scer_responder

// File: verif/scer_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the error responder
module scer_asserts
   import scer_pkg::*;
(
   input wire logic        i_core_clk,
   input wire logic        i_resetn,
   input wire logic        i_rx_valid,
   input wire scer_rx_t    i_rx,
   input wire scer_check_t i_check,
   input wire logic [7:0]  i_unit_addr,
   input wire logic        i_tx_ready,
   input wire logic        o_tx_valid,
   input wire logic [7:0]  o_tx_data,
   input wire logic        o_selected,
   input wire logic        o_busy
);
   logic err_seen; // Fault seen in this command
   logic fresh;    // No reply byte taken yet
   wire take = i_rx_valid && !o_busy;
   wire eoc = take && i_rx.data == CH_CR;
   wire bad = err_seen | i_rx.parity_err | i_rx.frame_err;
   wire live = i_unit_addr == ADDR_RST || o_selected;
   wire clean = eoc && !bad && live;
   wire acc = o_tx_valid && i_tx_ready;
   // Fault memory, cleared by the closing CR
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || eoc)
         err_seen <= 1'b0;
      else if (take && (i_rx.parity_err || i_rx.frame_err))
         err_seen <= 1'b1;
   end
   // Idle re-arms the first-byte marker
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || !o_busy)
         fresh <= 1'b1;
      else if (acc)
         fresh <= 1'b0;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   property p_hold;
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Reply byte changed while stalled");
   property p_parity;
      eoc && bad && live |-> ##[2:3] o_tx_valid && o_tx_data == 8'h39;
   endproperty
   a_parity: assert property (p_parity)
      else $error("No code 9 after faulty char");
   property p_chan;
      clean && i_check.verdict == SCER_OK && i_check.has_chan
         && i_check.chan > CHAN_MAX
         |-> ##[2:3] o_tx_valid && o_tx_data == 8'h31;
   endproperty
   a_chan: assert property (p_chan)
      else $error("No code 1 for bad channel");
   property p_syntax;
      clean && i_check.verdict == SCER_SYNTAX
         |-> ##[2:3] o_tx_valid && o_tx_data == 8'h33;
   endproperty
   a_syntax: assert property (p_syntax)
      else $error("No code 3 for bad syntax");
   property p_task;
      clean && i_check.verdict == SCER_TASK && i_check.chan <= CHAN_MAX
         |-> ##[2:3] o_tx_valid && o_tx_data == 8'h34;
   endproperty
   a_task: assert property (p_task)
      else $error("No code 4 for unfit channel");
   property p_text;
      clean && (i_check.verdict == SCER_UNKNOWN
         || i_check.verdict == SCER_PARTIAL)
         |-> ##[2:3] o_tx_valid && o_tx_data == 8'h45;
   endproperty
   a_text: assert property (p_text)
      else $error("Text reply does not open with E");
   property p_cr;
      acc && fresh && o_tx_data inside {8'h31, 8'h33, 8'h34, 8'h39}
         |=> ##[0:12] o_tx_valid && o_tx_data == CH_CR;
   endproperty
   a_cr: assert property (p_cr)
      else $error("Numeric code not closed by CR");
   property p_mute;
      eoc && !live |=> !o_tx_valid [*4];
   endproperty
   a_mute: assert property (p_mute)
      else $error("Unselected unit replied");
   c_num: cover property (acc && fresh && o_tx_data == 8'h39);
   c_text: cover property (acc && fresh && o_tx_data == 8'h45);
   c_sel: cover property ($rose(o_selected));
endmodule // scer_asserts

// File: verif/scer_host.sv
`timescale 1ns/1ps
// Host side of the link: takes reply bytes, stalls at random
module scer_host (
   input  wire logic       i_core_clk,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready
);
   logic [7:0] last; // Last byte taken, for waveform reading
   initial o_tx_ready = 1'b0;
   // Ready about three cycles in four, to exercise holding
   always @(negedge i_core_clk)
      o_tx_ready <= ($urandom % 4) != 0;
   // Capture of each accepted byte
   always @(posedge i_core_clk)
      if (i_tx_valid && o_tx_ready)
         last <= i_tx_data;
endmodule // scer_host

// File: verif/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the error responder
module tb_top;
   import scer_pkg::*;
   logic        i_core_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic        i_rx_valid = 1'b0;
   scer_rx_t    i_rx = '0;
   scer_check_t i_check = '0;
   logic [7:0]  i_unit_addr = 8'h00; // Non-addressed at first
   logic        i_tx_ready;
   logic        o_tx_valid;
   logic [7:0]  o_tx_data;
   logic        o_selected;
   logic        o_busy;
   logic [7:0]  exp_q[$]; // Expected reply bytes, oldest first
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   // 20 MHz core clock
   always #25 i_core_clk = ~i_core_clk;
   scer_responder dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
      .i_rx_valid(i_rx_valid), .i_rx(i_rx), .i_check(i_check),
      .i_unit_addr(i_unit_addr), .i_tx_ready(i_tx_ready),
      .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
      .o_selected(o_selected), .o_busy(o_busy));
   scer_host u_host (.i_core_clk(i_core_clk), .i_tx_valid(o_tx_valid),
      .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
   task chk(logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One char, one-cycle pulse, one idle cycle after
   task put(logic [7:0] ch, logic pe, logic fe);
      @(negedge i_core_clk);
      i_rx = '{ch, pe, fe};
      i_rx_valid = 1'b1;
      @(negedge i_core_clk);
      i_rx_valid = 1'b0;
   endtask
   // Command, then CR; f = 1 parity, 2 framing fault on first char
   task run(string s, scer_verdict_t v, logic [7:0] ch, int f, string e);
      int w;
      for (int i = 0; i < e.len(); i++)
         exp_q.push_back(e[i]);
      if (e.len() > 0)
         exp_q.push_back(CH_CR);
      i_check = '{v, 1'b1, ch};
      for (int i = 0; i < s.len(); i++)
         put(s[i], f == 1 && i == 0, f == 2 && i == 0);
      put(CH_CR, 1'b0, 1'b0);
      w = 0;
      while ((exp_q.size() > 0 || o_busy !== 1'b0) && w < 400) begin
         @(negedge i_core_clk);
         w++;
      end
      repeat (6) @(negedge i_core_clk);
      chk(8'(exp_q.size()), 8'h00);
      $display("test %s done", s);
   endtask
   // Monitor: every accepted byte against the oldest note
   always @(posedge i_core_clk)
      if (i_resetn && o_tx_valid && i_tx_ready)
         chk(o_tx_data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
   // Hang guard, far above the expected run length
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(81359));
      repeat (6) @(negedge i_core_clk);
      i_resetn = 1'b1;
      run("A9", SCER_OK, 8'h08 + 8'($urandom % 248), 0, "1");
      run("AZ", SCER_OK, 8'hFF, 0, "1");
      run("D", SCER_SYNTAX, 8'h00, 0, "3");
      run("D3", SCER_TASK, 8'h03, 0, "4");
      run("D3", SCER_TASK, 8'h03, 1, "9");
      run("D", SCER_SYNTAX, 8'h00, 2, "9");
      run("QZ", SCER_UNKNOWN, 8'h00, 0,
         "Error, Unrecognized Command: QZ");
      run("Vq", SCER_PARTIAL, 8'h00, 0,
         "Error, Command not fully recognized: Vq");
      run("D1", SCER_OK, 8'h01, 0, "");
      // Addressed mode from here on
      i_unit_addr = 8'h05;
      run("D", SCER_SYNTAX, 8'h00, 0, "");
      run("!05", SCER_OK, 8'h00, 0, "");
      chk(8'(o_selected), 8'h01);
      run("D", SCER_SYNTAX, 8'h00, 0, "3");
      run("!05X", SCER_OK, 8'h00, 0,
         "Error, Address command must be CR terminated");
      run("!06", SCER_OK, 8'h00, 0, "");
      chk(8'(o_selected), 8'h00);
      run("D", SCER_SYNTAX, 8'h00, 0, "");
      give_verdict();
   end
endmodule // tb_top
bind scer_responder scer_asserts u_chk (.i_core_clk(i_core_clk),
   .i_resetn(i_resetn), .i_rx_valid(i_rx_valid), .i_rx(i_rx),
   .i_check(i_check), .i_unit_addr(i_unit_addr), .i_tx_ready(i_tx_ready),
   .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
   .o_selected(o_selected), .o_busy(o_busy));
